// File: logic/cin_common_regs.sv
// Common network configuration registers and interrupt pin control
// What this block does
// - Gateway address, four bytes at 0x0001-0x0004, read/write, resets to zero.
// - Subnet mask, four bytes at 0x0005-0x0008, read/write, resets to zero.
// - Local hardware address, six bytes at 0x0009-0x000e, resets to zero.
// - Local IP address, four bytes at 0x000f-0x0012, resets to zero.
// - Nonzero delay holds the pin high (delay+1)*4 clocks before reasserting.
// - A new event while the pin is low only sets its flag.
// - Clearing the causing flag releases the pin even if others remain.
// - Common flag bits clear on writing one; writing zero keeps them.
// - Pin falls from idle when enabled common flags are pending.
// - ARP request with our own IP as sender sets flag bit 7.
// - ICMP port-unreachable sets flag bit 6.
// - Unreachable peer IP and port are captured into 0x0028-0x002d.
// - Session loss in PPPoE mode sets flag bit 5.
// - Magic packet with wake-on-LAN enabled sets bit 4; bits 3-0 reserved.
// - Wake-on-LAN enable comes in on wake_on_lan_enable_in and only gates the magic packet flag.
// - Common mask bits 7-4 gate the matching flags onto the pin.
// - Socket summary bit n is high while socket n has flags pending.
// - Pin falls from idle when enabled socket summary bits are pending.
// - Socket mask bits gate the matching summary bits onto the pin.
// - Retry period at 0x0019-0x001a in 100us units, resets to 0x07d0.
// - After a socket command packet, wait the retry period for a response.
`timescale 1ns/10ps
`include "cin_defs.svh"
module cin_common_regs
#(
   parameter int RETRY_TICK_CYCLES = `CIN_RETRY_TICK_CYCLES,
   parameter int NUM_SOCKETS       = `CIN_NUM_SOCKETS
)
(
   input  wire logic                   ref_clk_in,
   input  wire logic                   reset_in,
   input  wire logic [15:0]            reg_addr_in,
   input  wire logic                   reg_write_in,
   input  wire logic [7:0]             reg_wdata_in,
   input  wire logic                   reg_read_in,
   output logic [7:0]                  reg_rdata_out,
   output logic                        reg_rvalid_out,
   input  wire logic                   arp_request_in,
   input  wire logic [31:0]            arp_sender_ip_in,
   input  wire logic                   icmp_no_port_in,
   input  wire logic [31:0]            icmp_peer_ip_in,
   input  wire logic [15:0]            icmp_peer_port_in,
   input  wire logic                   session_closed_in,
   input  wire logic                   pppoe_mode_in,
   input  wire logic                   magic_packet_in,
   input  wire logic                   wake_on_lan_enable_in,
   input  wire logic [NUM_SOCKETS-1:0] socket_pending_in,
   input  wire logic [NUM_SOCKETS-1:0] retry_start_in,
   input  wire logic [NUM_SOCKETS-1:0] peer_response_in,
   output logic [NUM_SOCKETS-1:0]      retry_expired_out,
   output logic                        interrupt_out_n,
   output logic [31:0]                 gateway_ip_out,
   output logic [31:0]                 subnet_mask_out,
   output logic [47:0]                 local_mac_address_out,
   output logic [31:0]                 local_ip_address_out,
   output logic [15:0]                 retry_timeout_period_out
);
   import cin_pkg::*;

   cin_core_t   st;
   cin_core_t   next_st;
   logic [15:0] enabled;
   logic [15:0] int_reassert_delay;
   logic        release_now;

   // ****************************************
   // Address decoding
   // ****************************************
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic logic [7:0] read_byte(input logic [15:0] a, input cin_core_t s);
      logic [15:0] idx;
      idx       = 16'h0000;
      read_byte = 8'h00;
      if (in_range(a, `CIN_ADDR_NET_FIRST, `CIN_ADDR_NET_LAST))
      begin
         idx       = a - `CIN_ADDR_NET_FIRST;
         read_byte = s.net_bytes[idx[4:0]];
      end
      else if (in_range(a, `CIN_ADDR_ICMP_NO_PORT_FLAG_FIRST, `CIN_ADDR_ICMP_NO_PORT_FLAG_LAST))
      begin
         idx       = a - `CIN_ADDR_ICMP_NO_PORT_FLAG_FIRST;
         // Lowest address carries the most significant byte of the capture
         read_byte = s.icmp_no_port_flag[3'(`CIN_ICMP_NO_PORT_FLAG_BYTES - 1) - idx[2:0]];
      end
      else
      begin
         unique case (a)
            `CIN_ADDR_FLAGS:    read_byte = s.flags & `CIN_FLAG_IMPL;
            `CIN_ADDR_MASK:     read_byte = s.mask & `CIN_FLAG_IMPL;
            `CIN_ADDR_SUMMARY:  read_byte = s.summary;
            `CIN_ADDR_SMASK:    read_byte = s.smask;
            `CIN_ADDR_RETRY_HI: read_byte = s.retry_period[15:8];
            `CIN_ADDR_RETRY_LO: read_byte = s.retry_period[7:0];
            default:            read_byte = 8'h00;
         endcase
      end
   endfunction : read_byte

   // ****************************************
   // Field views, lowest address is most significant
   // ****************************************
   assign gateway_ip_out           = {st.net_bytes[0], st.net_bytes[1], st.net_bytes[2], st.net_bytes[3]};
   assign subnet_mask_out          = {st.net_bytes[4], st.net_bytes[5], st.net_bytes[6], st.net_bytes[7]};
   assign local_mac_address_out    = {st.net_bytes[8], st.net_bytes[9], st.net_bytes[10],
                                      st.net_bytes[11], st.net_bytes[12], st.net_bytes[13]};
   assign local_ip_address_out     = {st.net_bytes[14], st.net_bytes[15], st.net_bytes[16], st.net_bytes[17]};
   assign int_reassert_delay       = {st.net_bytes[18], st.net_bytes[19]};
   assign retry_timeout_period_out = st.retry_period;
   assign reg_rdata_out            = st.rdata;
   assign reg_rvalid_out           = st.rvalid;
   assign interrupt_out_n          = (st.pin_state != CIN_PIN_LOW);

   // Common flags above, socket summary below
   assign enabled     = {st.flags & st.mask & `CIN_FLAG_IMPL, st.summary & st.smask};
   assign release_now = (st.pin_state == CIN_PIN_LOW) && ((st.cause & enabled) == 16'h0000);

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      logic [15:0] widx;
      logic [7:0]  set_bits;
      widx     = reg_addr_in - `CIN_ADDR_NET_FIRST;
      set_bits = 8'h00;
      next_st  = st;

      // Unit tick for the retry timers
      next_st.tick = 1'b0;
      if (st.tick_count == 16'(RETRY_TICK_CYCLES - 1))
      begin
         next_st.tick_count = 16'h0000;
         next_st.tick       = 1'b1;
      end
      else
      begin
         next_st.tick_count = st.tick_count + 16'h0001;
      end

      // Host register writes
      if (reg_write_in)
      begin
         if (in_range(reg_addr_in, `CIN_ADDR_NET_FIRST, `CIN_ADDR_NET_LAST))
         begin
            next_st.net_bytes[widx[4:0]] = reg_wdata_in;
         end
         else
         begin
            unique case (reg_addr_in)
               `CIN_ADDR_FLAGS:    next_st.flags = st.flags & ~reg_wdata_in;
               `CIN_ADDR_MASK:     next_st.mask  = reg_wdata_in & `CIN_FLAG_IMPL;
               `CIN_ADDR_SMASK:    next_st.smask = reg_wdata_in;
               `CIN_ADDR_RETRY_HI: next_st.retry_period[15:8] = reg_wdata_in;
               `CIN_ADDR_RETRY_LO: next_st.retry_period[7:0]  = reg_wdata_in;
               default:            next_st.flags = next_st.flags;
            endcase
         end
      end

      // Event flags; a set in the same cycle as a clear wins
      if (arp_request_in && (arp_sender_ip_in == local_ip_address_out))
         set_bits[`CIN_FLAG_CLASH] = 1'b1;
      if (icmp_no_port_in)
      begin
         set_bits[`CIN_FLAG_NO_PORT] = 1'b1;
         next_st.icmp_no_port_flag = {icmp_peer_ip_in, icmp_peer_port_in};
      end
      if (session_closed_in && pppoe_mode_in)
         set_bits[`CIN_FLAG_SESSION_CLOSE] = 1'b1;
      if (magic_packet_in && wake_on_lan_enable_in)
         set_bits[`CIN_FLAG_WAKE] = 1'b1;
      next_st.flags = (next_st.flags | set_bits) & `CIN_FLAG_IMPL;

      // Summary tracks the sockets' own flag registers
      next_st.summary = 8'(socket_pending_in);

      // Registered read answer
      next_st.rvalid = reg_read_in;
      if (reg_read_in)
         next_st.rdata = read_byte(reg_addr_in, st);

      // Interrupt pin sequencing
      unique case (st.pin_state)
         CIN_PIN_IDLE:
         begin
            if (enabled != 16'h0000)
            begin
               // Only what is pending now counts as the cause
               next_st.pin_state = CIN_PIN_LOW;
               next_st.cause     = enabled;
            end
         end
         CIN_PIN_LOW:
         begin
            // Late arrivals do not join the cause
            if (release_now)
            begin
               if (int_reassert_delay != 16'h0000)
               begin
                  next_st.pin_state  = CIN_PIN_HOLD;
                  next_st.hold_count = 18'((32'(int_reassert_delay) + 1) * `CIN_IAWT_STEP_CYCLES - 1);
               end
               else
               begin
                  next_st.pin_state = CIN_PIN_IDLE;
               end
            end
         end
         CIN_PIN_HOLD:
         begin
            if (st.hold_count == 18'h00000)
            begin
               next_st.pin_state = (enabled != 16'h0000) ? CIN_PIN_LOW : CIN_PIN_IDLE;
               next_st.cause     = enabled;
            end
            else
            begin
               next_st.hold_count = st.hold_count - 18'h00001;
            end
         end
         default:
         begin
            next_st.pin_state = CIN_PIN_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         st              <= '0;
         st.pin_state    <= CIN_PIN_IDLE;
         st.retry_period <= `CIN_RETRY_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ****************************************
   // Per-socket retransmission waits
   // ****************************************
   genvar s;
   generate
      for (s = 0; s < NUM_SOCKETS; s = s + 1)
      begin : g_retry
         cin_retry_timer u_timer
         (
            .ref_clk_in   (ref_clk_in),
            .reset_in     (reset_in),
            .unit_tick_in (st.tick),
            .start_in     (retry_start_in[s]),
            .response_in  (peer_response_in[s]),
            .period_in    (st.retry_period),
            .expired_out  (retry_expired_out[s])
         );
      end
   endgenerate

   // ****************************************
   // Checks
   // ****************************************
   property p_flag_clear;
      @(posedge ref_clk_in) disable iff (reset_in)
      (reg_write_in && reg_addr_in == `CIN_ADDR_FLAGS && !arp_request_in && !icmp_no_port_in
       && !session_closed_in && !magic_packet_in)
      |=> ((st.flags & $past(reg_wdata_in)) == 8'h00) && ((st.flags | $past(reg_wdata_in)) == ($past(st.flags) | $past(reg_wdata_in)));
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag write-one-to-clear misbehaved");

   property p_clash_wins;
      @(posedge ref_clk_in) disable iff (reset_in)
      (arp_request_in && arp_sender_ip_in == local_ip_address_out) |=> st.flags[`CIN_FLAG_CLASH];
   endproperty
   a_clash_wins: assert property (p_clash_wins)
      else $error("address clash flag not set");

   property p_icmp_no_port_flag_capture;
      @(posedge ref_clk_in) disable iff (reset_in)
      icmp_no_port_in |=> st.flags[`CIN_FLAG_NO_PORT] && st.icmp_no_port_flag == {$past(icmp_peer_ip_in), $past(icmp_peer_port_in)};
   endproperty
   a_icmp_no_port_flag_capture: assert property (p_icmp_no_port_flag_capture)
      else $error("unreachable peer not captured");

   property p_session_close;
      @(posedge ref_clk_in) disable iff (reset_in)
      (session_closed_in && pppoe_mode_in) |=> st.flags[`CIN_FLAG_SESSION_CLOSE];
   endproperty
   a_session_close: assert property (p_session_close)
      else $error("session close flag not set");

   property p_wake_packet;
      @(posedge ref_clk_in) disable iff (reset_in)
      (magic_packet_in && wake_on_lan_enable_in) |=> st.flags[`CIN_FLAG_WAKE] && st.flags[3:0] == 4'h0;
   endproperty
   a_wake_packet: assert property (p_wake_packet)
      else $error("wake packet flag not set or reserved bits set");

   property p_fall_needs_enabled;
      @(posedge ref_clk_in) disable iff (reset_in)
      $fell(interrupt_out_n) |-> $past(enabled) != 16'h0000;
   endproperty
   a_fall_needs_enabled: assert property (p_fall_needs_enabled)
      else $error("pin fell with nothing enabled pending");

   property p_zero_delay;
      @(posedge ref_clk_in) disable iff (reset_in)
      (st.pin_state == CIN_PIN_IDLE && enabled != 16'h0000) |=> !interrupt_out_n;
   endproperty
   a_zero_delay: assert property (p_zero_delay)
      else $error("pin did not fall with enabled flag pending");

   property p_hold_high;
      @(posedge ref_clk_in) disable iff (reset_in)
      (release_now && int_reassert_delay != 16'h0000) |=> interrupt_out_n [*8];
   endproperty
   a_hold_high: assert property (p_hold_high)
      else $error("pin reasserted before the wait expired");

   property p_stay_low;
      @(posedge ref_clk_in) disable iff (reset_in)
      (!interrupt_out_n && (st.cause & enabled) != 16'h0000) |=> !interrupt_out_n;
   endproperty
   a_stay_low: assert property (p_stay_low)
      else $error("pin released while cause still pending");

   property p_summary_follow;
      @(posedge ref_clk_in) disable iff (reset_in)
      !$past(reset_in) |-> st.summary == 8'($past(socket_pending_in));
   endproperty
   a_summary_follow: assert property (p_summary_follow)
      else $error("socket summary does not follow socket flags");

   property p_retry_reset;
      @(posedge ref_clk_in) disable iff (reset_in)
      $past(reset_in) |-> st.retry_period == `CIN_RETRY_RESET;
   endproperty
   a_retry_reset: assert property (p_retry_reset)
      else $error("retry period reset value wrong");

endmodule : cin_common_regs

// File: logic/cin_defs.svh
// Offsets, field positions, reset values and timing counts of the common register group
`ifndef CIN_DEFS_SVH
`define CIN_DEFS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define CIN_ADDR_NET_FIRST     16'h0001
`define CIN_ADDR_GATEWAY       16'h0001
`define CIN_ADDR_SUBNET        16'h0005
`define CIN_ADDR_MAC           16'h0009
`define CIN_ADDR_LOCAL_IP      16'h000f
`define CIN_ADDR_DELAY         16'h0013
`define CIN_ADDR_NET_LAST      16'h0014
`define CIN_ADDR_FLAGS         16'h0015
`define CIN_ADDR_MASK          16'h0016
`define CIN_ADDR_SUMMARY       16'h0017
`define CIN_ADDR_SMASK         16'h0018
`define CIN_ADDR_RETRY_HI      16'h0019
`define CIN_ADDR_RETRY_LO      16'h001a
`define CIN_ADDR_ICMP_NO_PORT_FLAG_FIRST 16'h0028
`define CIN_ADDR_ICMP_NO_PORT_FLAG_LAST  16'h002d

// ****************************************
// Byte counts and field positions
// ****************************************
`define CIN_NET_BYTES          20
`define CIN_ICMP_NO_PORT_FLAG_BYTES      6
`define CIN_NUM_SOCKETS        8
`define CIN_FLAG_CLASH         7
`define CIN_FLAG_NO_PORT       6
`define CIN_FLAG_SESSION_CLOSE 5
`define CIN_FLAG_WAKE          4
`define CIN_FLAG_IMPL          8'hf0

// ****************************************
// Reset values
// ****************************************
`define CIN_BYTE_RESET         8'h00
`define CIN_RETRY_RESET        16'h07d0

// ****************************************
// Timing
// ****************************************
`define CIN_CLK_PERIOD_PS      4000
`define CIN_RETRY_UNIT_PS      100000000
`define CIN_RETRY_TICK_CYCLES  (`CIN_RETRY_UNIT_PS / `CIN_CLK_PERIOD_PS)
`define CIN_IAWT_STEP_CYCLES   4

`endif

// File: logic/cin_pkg.sv
// Types shared by the common register group and its retry timers
package cin_pkg;
`include "cin_defs.svh"

   typedef enum logic [2:0] {
      CIN_PIN_IDLE = 3'b001,
      CIN_PIN_LOW  = 3'b010,
      CIN_PIN_HOLD = 3'b100
   } cin_pin_state_t;

   typedef struct packed {
      cin_pin_state_t                         pin_state;
      logic [15:0]                            cause;
      logic [17:0]                            hold_count;
      logic [15:0]                            tick_count;
      logic                                   tick;
      logic [`CIN_NET_BYTES-1:0][7:0]         net_bytes;
      logic [7:0]                             flags;
      logic [7:0]                             mask;
      logic [7:0]                             summary;
      logic [7:0]                             smask;
      logic [15:0]                            retry_period;
      logic [`CIN_ICMP_NO_PORT_FLAG_BYTES-1:0][7:0]     icmp_no_port_flag;
      logic [7:0]                             rdata;
      logic                                   rvalid;
   } cin_core_t;

   typedef struct packed {
      logic [15:0] remaining;
      logic        active;
      logic        expired;
   } cin_timer_t;

endpackage : cin_pkg

// File: logic/cin_retry_timer.sv
// Per-socket retransmission wait timer counted in retry-period units
`timescale 1ns/10ps
module cin_retry_timer
(
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   input  wire logic        unit_tick_in,
   input  wire logic        start_in,
   input  wire logic        response_in,
   input  wire logic [15:0] period_in,
   output logic             expired_out
);
   import cin_pkg::*;

   cin_timer_t st;
   cin_timer_t next_st;

   // ****************************************
   // Wait for the peer, then report expiry
   // ****************************************
   always_comb
   begin
      next_st         = st;
      next_st.expired = 1'b0;
      if (start_in)
      begin
         // Restart on every new packet sent
         next_st.active    = 1'b1;
         next_st.remaining = period_in;
      end
      else if (response_in)
      begin
         next_st.active = 1'b0;
      end
      else if (st.active && unit_tick_in)
      begin
         if (st.remaining <= 16'h0001)
         begin
            // Owner retransmits or times out on this pulse
            next_st.active  = 1'b0;
            next_st.expired = 1'b1;
         end
         else
         begin
            next_st.remaining = st.remaining - 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         st <= '0;
      else
         st <= next_st;
   end

   assign expired_out = st.expired;

   property p_expire_needs_wait;
      @(posedge ref_clk_in) disable iff (reset_in)
      expired_out |-> $past(st.active) && !$past(start_in) && !$past(response_in);
   endproperty
   a_expire_needs_wait: assert property (p_expire_needs_wait)
      else $error("retry expiry without a running wait");

endmodule : cin_retry_timer

// File: tb/cin_common_regs_bench.sv
// Self-checking bench for the common register group
`timescale 1ns/10ps
module cin_common_regs_bench;
   logic        clk, rst, wr_s, rd_s, rvalid, arp, icmp, sess, pppoe, magic, wake_on_lan_enable, irq_n;
   logic [15:0] addr, rtp;
   logic [7:0]  wdata, rdata, pend, start, resp, expired;
   logic [31:0] aip, gw, sm, lip;
   logic [47:0] mac;
   int          errors, samples_checked, c, n;
   cin_host_model u_host (.ref_clk_in(clk), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
      .reg_addr_out(addr), .reg_write_out(wr_s), .reg_wdata_out(wdata), .reg_read_out(rd_s));
   cin_common_regs #(.RETRY_TICK_CYCLES(4)) u_dut (.ref_clk_in(clk), .reset_in(rst),
      .reg_addr_in(addr), .reg_write_in(wr_s), .reg_wdata_in(wdata), .reg_read_in(rd_s),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .arp_request_in(arp), .arp_sender_ip_in(aip),
      .icmp_no_port_in(icmp), .icmp_peer_ip_in(aip), .icmp_peer_port_in(aip[15:0]),
      .session_closed_in(sess), .pppoe_mode_in(pppoe), .magic_packet_in(magic),
      .wake_on_lan_enable_in(wake_on_lan_enable), .socket_pending_in(pend), .retry_start_in(start),
      .peer_response_in(resp), .retry_expired_out(expired), .interrupt_out_n(irq_n),
      .gateway_ip_out(gw), .subnet_mask_out(sm), .local_mac_address_out(mac),
      .local_ip_address_out(lip), .retry_timeout_period_out(rtp));
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rc(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      u_host.rd(a, d, v);
      check(v, 1'b1);
      check(d, e);
   endtask : rc
   // Events {arp, icmp, sess, magic}, socket starts and answers, each high for one cycle
   task automatic pulse(input logic [3:0] ev, input logic [7:0] go, input logic [7:0] ack);
      @(posedge clk);
      #1;
      {arp, icmp, sess, magic} = ev;
      start = go;
      resp  = ack;
      @(posedge clk);
      #1;
      {arp, icmp, sess, magic} = 4'h0;
      start = 8'h00;
      resp  = 8'h00;
   endtask : pulse
   // Bounded wait for the pin level, returns cycles waited
   task automatic pin(input logic l, output int k);
      k = 0;
      while (irq_n !== l && k < 99)
      begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask : pin
   task automatic results();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      #60000;
      errors++;
      results();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      {arp, icmp, sess, pppoe, magic, wake_on_lan_enable, pend, start, resp, aip} = '0;
      errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      check(irq_n, 1'b1);
      for (int a = 1; a <= 26; a++) rc(a[15:0], a == 25 ? 8'h07 : a == 26 ? 8'hd0 : 8'h00);
      rc(16'h0030, 8'h00);
      $display("reset test done");
      for (int a = 1; a <= 18; a++) u_host.wr(a[15:0], a[7:0] ^ 8'h5a);
      for (int a = 1; a <= 18; a++) rc(a[15:0], a[7:0] ^ 8'h5a);
      check(gw, 32'h5b58595e);
      check(sm, 32'h5f5c5d52);
      check(mac, 48'h535051565754);
      check(lip, 32'h554a4b48);
      u_host.wr(16'h0017, 8'hff);
      rc(16'h0017, 8'h00);
      $display("network register test done");
      u_host.wr(16'h0016, 8'hff);
      rc(16'h0016, 8'hf0);
      aip = 32'h01020304;
      pulse(4'h8, 8'h00, 8'h00);
      rc(16'h0015, 8'h00);
      aip = 32'h554a4b48;
      pulse(4'h8, 8'h00, 8'h00);
      pin(1'b0, c);
      check(c, 1);
      aip = 32'hc0a8000b;
      pulse(4'h4, 8'h00, 8'h00);
      rc(16'h0015, 8'hc0);
      check(irq_n, 1'b0);
      for (int i = 0; i < 6; i++) rc(16'h0028 + 16'(i), 8'(48'hc0a8000b000b >> (40 - 8 * i)));
      u_host.clr(8'h80);
      pin(1'b1, c);
      check(c <= 2, 1'b1);
      pin(1'b0, c);
      check(c <= 2, 1'b1);
      u_host.wr(16'h0015, 8'h00);
      rc(16'h0015, 8'h40);
      u_host.clr(8'h40);
      rc(16'h0015, 8'h00);
      check(irq_n, 1'b1);
      u_host.wr(16'h0016, 8'h00);
      pulse(4'h1, 8'h00, 8'h00);
      rc(16'h0015, 8'h00);
      wake_on_lan_enable = 1'b1;
      pulse(4'h1, 8'h00, 8'h00);
      rc(16'h0015, 8'h10);
      check(irq_n, 1'b1);
      u_host.wr(16'h0016, 8'hf0);
      pin(1'b0, c);
      check(c <= 2, 1'b1);
      u_host.clr(8'h10);
      $display("common flag test done");
      u_host.wr(16'h0014, 8'h02);
      pulse(4'h2, 8'h00, 8'h00);
      rc(16'h0015, 8'h00);
      pppoe = 1'b1;
      pulse(4'h2, 8'h00, 8'h00);
      pin(1'b0, c);
      pulse(4'h1, 8'h00, 8'h00);
      rc(16'h0015, 8'h30);
      u_host.clr(8'h20);
      pin(1'b1, c);
      for (n = 0; irq_n === 1'b1 && n < 99; n++) @(posedge clk) #1;
      check(n, 12);
      u_host.clr(8'h10);
      repeat (16) @(posedge clk);
      u_host.wr(16'h0014, 8'h00);
      $display("reassert delay test done");
      u_host.wr(16'h0018, 8'h01);
      pend = 8'h02;
      rc(16'h0017, 8'h02);
      check(irq_n, 1'b1);
      pend = 8'h03;
      pin(1'b0, c);
      check(c <= 3, 1'b1);
      pend = 8'h02;
      pin(1'b1, c);
      check(c <= 3, 1'b1);
      pend = 8'h00;
      $display("socket summary test done");
      u_host.wr(16'h0019, 8'h00);
      u_host.wr(16'h001a, 8'h03);
      check(rtp, 16'h0003);
      pulse(4'h0, 8'h04, 8'h00);
      for (n = 0; expired[2] !== 1'b1 && n < 99; n++) @(posedge clk) #1;
      check(n >= 7 && n <= 14, 1'b1);
      @(posedge clk) #1;
      check(expired, 8'h00);
      // An answer from the peer stops the wait, so no expiry may follow
      pulse(4'h0, 8'h04, 8'h00);
      pulse(4'h0, 8'h00, 8'h04);
      for (n = 0; expired === 8'h00 && n < 40; n++) @(posedge clk) #1;
      check(n, 40);
      // Start beats an answer in the same cycle, so the wait still runs out
      pulse(4'h0, 8'h04, 8'h04);
      for (n = 0; expired[2] !== 1'b1 && n < 99; n++) @(posedge clk) #1;
      check(n >= 7 && n <= 14, 1'b1);
      $display("retry timer test done");
      results();
   end
endmodule : cin_common_regs_bench

// File: tb/cin_host_model.sv
// Host model driving the byte-wide register port of the common register group
`timescale 1ns/10ps
module cin_host_model
(
   input  wire logic        ref_clk_in,
   input  wire logic [7:0]  reg_rdata_in,
   input  wire logic        reg_rvalid_in,
   output logic      [15:0] reg_addr_out,
   output logic             reg_write_out,
   output logic      [7:0]  reg_wdata_out,
   output logic             reg_read_out
);
   initial
   begin
      reg_addr_out  = 16'h0000;
      reg_write_out = 1'b0;
      reg_wdata_out = 8'h00;
      reg_read_out  = 1'b0;
   end
   // Data inverted on release so a stale byte is never mistaken for a fresh one
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      #1;
      reg_addr_out  = a;
      reg_wdata_out = d;
      reg_write_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      reg_write_out = 1'b0;
      reg_wdata_out = ~d;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(posedge ref_clk_in);
      #1;
      reg_addr_out = a;
      reg_read_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      reg_read_out = 1'b0;
      d = reg_rdata_in;
      v = reg_rvalid_in;
   endtask : rd
   task automatic clr(input logic [7:0] bits);
      wr(16'h0015, bits);
   endtask : clr
endmodule : cin_host_model
